/* File: include/pin_select_matrix_defines.svh */
`ifndef PIN_SELECT_MATRIX_DEFINES_SVH
`define PIN_SELECT_MATRIX_DEFINES_SVH

// Word indexes inside the block (byte address is four times the index)
`define IN_ROUTE_FIRST 10'h000
`define IN_ROUTE_REGS 12
`define OUT_ROUTE_FIRST 10'h010
`define OUT_ROUTE_REGS 13
`define OSC_CTRL_WORD 10'h020
`define WORD_INDEX_W 10

// Field layout of the routing registers
`define IN_SEL_W 6
`define OUT_SEL_W 5
`define FIELD_HI_POS 8
`define FIELDS_PER_REG 2
`define ROUTED_INPUTS 23
`define MAX_PINS 32

// Reset values
`define IN_SEL_RESET 6'h3F
`define OUT_SEL_NULL 5'h00
`define ROUTE_LOCK_RESET 1'b0

// Oscillator control byte and its unlock keys
`define LOCK_BIT_POS 6
`define UNLOCK_KEY1 8'h46
`define UNLOCK_KEY2 8'h57

// Output function codes
`define FN_COMPARATOR1 5'h01
`define FN_COMPARATOR2 5'h02
`define FN_UART1_TX 5'h03
`define FN_UART1_RTS 5'h04
`define FN_UART2_TX 5'h05
`define FN_UART2_RTS 5'h06
`define FN_SERIAL1_DATA 5'h07
`define FN_SERIAL1_CLOCK 5'h08
`define FN_SERIAL1_SELECT 5'h09
`define FN_SERIAL2_DATA 5'h0A
`define FN_SERIAL2_CLOCK 5'h0B
`define FN_SERIAL2_SELECT 5'h0C
`define FN_COMPARE1 5'h12
`define FN_COMPARE2 5'h13
`define FN_COMPARE3 5'h14
`define FN_COMPARE4 5'h15
`define FN_COMPARE5 5'h16
`define FN_CHARGE_PULSE 5'h1D
`define FN_COMPARATOR3 5'h1E

// Bus encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

/* File: include/pin_select_matrix_pkg.sv */
package pin_select_matrix_pkg;

  // Peripheral inputs; the last field is routed input 0
  typedef struct packed {
    logic uart2ClearToSend;
    logic uart2Receive;
    logic uart1ClearToSend;
    logic uart1Receive;
    logic timer5ExtClock;
    logic timer4ExtClock;
    logic timer3ExtClock;
    logic timer2ExtClock;
    logic serial2SelectIn;
    logic serial2DataIn;
    logic serial2ClockIn;
    logic serial1SelectIn;
    logic serial1DataIn;
    logic serial1ClockIn;
    logic compareFaultBIn;
    logic compareFaultAIn;
    logic capture5In;
    logic capture4In;
    logic capture3In;
    logic capture2In;
    logic capture1In;
    logic extIrq2In;
    logic extIrq1In;
  } periph_in_type;

  typedef struct packed {
    logic comparator1Out;
    logic comparator2Out;
    logic comparator3Out;
    logic uart1Transmit;
    logic uart1RequestToSend;
    logic uart2Transmit;
    logic uart2RequestToSend;
    logic serial1DataOut;
    logic serial1ClockOut;
    logic serial1SelectOut;
    logic serial2DataOut;
    logic serial2ClockOut;
    logic serial2SelectOut;
    logic compare1Out;
    logic compare2Out;
    logic compare3Out;
    logic compare4Out;
    logic compare5Out;
    logic chargeTimePulse;
  } periph_out_type;

  // Fixed port logic of one pin
  typedef struct packed {
    logic analogEn;
    logic specialEn;
    logic specialData;
    logic pinDirectionBit;
    logic portData;
  } pin_ctl_type;

  typedef enum logic [1:0] {BUS_IDLE, BUS_READ} bus_state_type;
  typedef enum logic [1:0] {KEY_WAIT1, KEY_WAIT2, KEY_OPEN} unlock_state_type;

endpackage

/* File: core/input_route_sel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_matrix_defines.svh"

module input_route_sel #(
  parameter int NUM_PINS = 26
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Pin side
  input wire logic [NUM_PINS-1:0] pinLevel,
  input wire logic [NUM_PINS-1:0] analogEn,
  // Selection and result
  input wire logic [`IN_SEL_W-1:0] sel,
  output logic routed
);

  logic picked;

  always_comb begin
    picked = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      // Absent pins and analog pins give a low level
      if (sel == p[`IN_SEL_W-1:0] && !analogEn[p]) begin
        picked = pinLevel[p];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      routed <= 1'b0;
    end else begin
      routed <= picked;
    end
  end

endmodule
`default_nettype wire

/* File: core/output_pin_drive.sv */
`timescale 1ns/1ps
`default_nettype none

module output_pin_drive (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Sources
  input wire pin_select_matrix_pkg::pin_ctl_type ctl,
  input wire logic remapOn,
  input wire logic remapData,
  // Pad
  output logic padOut,
  output logic padOeB
);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      padOut <= 1'b0;
      padOeB <= 1'b1;
    end else if (ctl.specialEn) begin
      padOut <= ctl.specialData;
      padOeB <= 1'b0;
    end else if (remapOn) begin
      padOut <= remapData;
      padOeB <= 1'b0;
    end else begin
      // Input routing never touches the buffer
      padOut <= ctl.portData;
      padOeB <= ctl.pinDirectionBit;
    end
  end

endmodule
`default_nettype wire

/* File: core/pin_select_matrix.sv */
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_matrix_defines.svh"

module pin_select_matrix #(
  parameter int NUM_PINS = 26
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Remappable pads
  input wire logic [NUM_PINS-1:0] padIn,
  input wire pin_select_matrix_pkg::pin_ctl_type [NUM_PINS-1:0] pinCtl,
  output logic [NUM_PINS-1:0] padOut,
  output logic [NUM_PINS-1:0] padOeB,
  // Peripherals
  input wire pin_select_matrix_pkg::periph_out_type periphOut,
  output pin_select_matrix_pkg::periph_in_type periphIn,
  output logic routeLocked
);

  localparam int NIN = `ROUTED_INPUTS;

  pin_select_matrix_pkg::bus_state_type busState;
  pin_select_matrix_pkg::unlock_state_type keyState;

  logic [`IN_SEL_W-1:0] inSel [NIN];
  logic [`OUT_SEL_W-1:0] outSel [NUM_PINS];
  logic [NUM_PINS-1:0] padMeta;
  logic [NUM_PINS-1:0] padSync;
  logic [NUM_PINS-1:0] analogMask;
  logic [NIN-1:0] routedIn;
  logic [NUM_PINS-1:0] remapOn;
  logic [NUM_PINS-1:0] remapData;
  logic wrPend;
  logic [`WORD_INDEX_W-1:0] wrIdx;
  logic [`WORD_INDEX_W-1:0] rdIdx;
  logic [31:0] rdWord;
  logic takeReq;
  logic wrOsc;
  logic routeWrite;

  // Connected output code, and the level of the function it names
  function automatic logic codeLive(input logic [`OUT_SEL_W-1:0] code);
    case (code)
      `FN_COMPARATOR1, `FN_COMPARATOR2, `FN_COMPARATOR3,
      `FN_UART1_TX, `FN_UART1_RTS, `FN_UART2_TX, `FN_UART2_RTS,
      `FN_SERIAL1_DATA, `FN_SERIAL1_CLOCK, `FN_SERIAL1_SELECT,
      `FN_SERIAL2_DATA, `FN_SERIAL2_CLOCK, `FN_SERIAL2_SELECT,
      `FN_COMPARE1, `FN_COMPARE2, `FN_COMPARE3, `FN_COMPARE4, `FN_COMPARE5,
      `FN_CHARGE_PULSE: codeLive = 1'b1;
      default: codeLive = 1'b0;
    endcase
  endfunction

  function automatic logic codeLevel(input logic [`OUT_SEL_W-1:0] code,
                                     input pin_select_matrix_pkg::periph_out_type po);
    case (code)
      `FN_COMPARATOR1: codeLevel = po.comparator1Out;
      `FN_COMPARATOR2: codeLevel = po.comparator2Out;
      `FN_COMPARATOR3: codeLevel = po.comparator3Out;
      `FN_UART1_TX: codeLevel = po.uart1Transmit;
      `FN_UART1_RTS: codeLevel = po.uart1RequestToSend;
      `FN_UART2_TX: codeLevel = po.uart2Transmit;
      `FN_UART2_RTS: codeLevel = po.uart2RequestToSend;
      `FN_SERIAL1_DATA: codeLevel = po.serial1DataOut;
      `FN_SERIAL1_CLOCK: codeLevel = po.serial1ClockOut;
      `FN_SERIAL1_SELECT: codeLevel = po.serial1SelectOut;
      `FN_SERIAL2_DATA: codeLevel = po.serial2DataOut;
      `FN_SERIAL2_CLOCK: codeLevel = po.serial2ClockOut;
      `FN_SERIAL2_SELECT: codeLevel = po.serial2SelectOut;
      `FN_COMPARE1: codeLevel = po.compare1Out;
      `FN_COMPARE2: codeLevel = po.compare2Out;
      `FN_COMPARE3: codeLevel = po.compare3Out;
      `FN_COMPARE4: codeLevel = po.compare4Out;
      `FN_COMPARE5: codeLevel = po.compare5Out;
      `FN_CHARGE_PULSE: codeLevel = po.chargeTimePulse;
      default: codeLevel = 1'b0;
    endcase
  endfunction

  // Bus request decode
  assign takeReq = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
  assign wrOsc = wrPend && (wrIdx == `OSC_CTRL_WORD);
  assign routeWrite = wrPend && !routeLocked;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      busState <= pin_select_matrix_pkg::BUS_IDLE;
      hreadyout <= 1'b1;
      wrPend <= 1'b0;
      wrIdx <= '0;
      rdIdx <= '0;
    end else begin
      wrPend <= 1'b0;
      case (busState)
        pin_select_matrix_pkg::BUS_IDLE: begin
          if (takeReq && hwrite) begin
            wrPend <= 1'b1;
            wrIdx <= haddr[`WORD_INDEX_W+1:2];
          end else if (takeReq) begin
            // One wait state lets a read see a write committed just before
            rdIdx <= haddr[`WORD_INDEX_W+1:2];
            hreadyout <= 1'b0;
            busState <= pin_select_matrix_pkg::BUS_READ;
          end
        end
        pin_select_matrix_pkg::BUS_READ: begin
          hreadyout <= 1'b1;
          busState <= pin_select_matrix_pkg::BUS_IDLE;
        end
        default: begin
          hreadyout <= 1'b1;
          busState <= pin_select_matrix_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hrdata <= '0;
      hresp <= `HRESP_OKAY;
    end else if (busState == pin_select_matrix_pkg::BUS_READ) begin
      hrdata <= rdWord;
    end
  end

  // Read mux: two fields per word, unmapped words read zero
  always_comb begin
    rdWord = '0;
    for (int i = 0; i < NIN; i++) begin
      if (rdIdx == `IN_ROUTE_FIRST + (i / `FIELDS_PER_REG)) begin
        rdWord[(i % `FIELDS_PER_REG) * `FIELD_HI_POS +: `IN_SEL_W] = inSel[i];
      end
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      if (rdIdx == `OUT_ROUTE_FIRST + (p / `FIELDS_PER_REG)) begin
        rdWord[(p % `FIELDS_PER_REG) * `FIELD_HI_POS +: `OUT_SEL_W] = outSel[p];
      end
    end
    if (rdIdx == `OSC_CTRL_WORD) begin
      rdWord[`LOCK_BIT_POS] = routeLocked;
    end
  end

  // Input selects, one field per peripheral input
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int i = 0; i < NIN; i++) begin
        inSel[i] <= `IN_SEL_RESET;
      end
    end else if (routeWrite) begin
      for (int i = 0; i < NIN; i++) begin
        if (wrIdx == `IN_ROUTE_FIRST + (i / `FIELDS_PER_REG)) begin
          inSel[i] <= hwdata[(i % `FIELDS_PER_REG) * `FIELD_HI_POS +: `IN_SEL_W];
        end
      end
    end
  end

  // Output selects, one field per pin
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        outSel[p] <= `OUT_SEL_NULL;
      end
    end else if (routeWrite) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (wrIdx == `OUT_ROUTE_FIRST + (p / `FIELDS_PER_REG)) begin
          outSel[p] <= hwdata[(p % `FIELDS_PER_REG) * `FIELD_HI_POS +: `OUT_SEL_W];
        end
      end
    end
  end

  // Lock changes only after the two keys, on consecutive control writes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      keyState <= pin_select_matrix_pkg::KEY_WAIT1;
      routeLocked <= `ROUTE_LOCK_RESET;
    end else if (wrPend && !wrOsc) begin
      keyState <= pin_select_matrix_pkg::KEY_WAIT1;
    end else if (wrOsc) begin
      case (keyState)
        pin_select_matrix_pkg::KEY_WAIT1: begin
          if (hwdata[7:0] == `UNLOCK_KEY1) begin
            keyState <= pin_select_matrix_pkg::KEY_WAIT2;
          end
        end
        pin_select_matrix_pkg::KEY_WAIT2: begin
          if (hwdata[7:0] == `UNLOCK_KEY2) begin
            keyState <= pin_select_matrix_pkg::KEY_OPEN;
          end else if (hwdata[7:0] != `UNLOCK_KEY1) begin
            keyState <= pin_select_matrix_pkg::KEY_WAIT1;
          end
        end
        pin_select_matrix_pkg::KEY_OPEN: begin
          routeLocked <= hwdata[`LOCK_BIT_POS];
          keyState <= pin_select_matrix_pkg::KEY_WAIT1;
        end
        default: keyState <= pin_select_matrix_pkg::KEY_WAIT1;
      endcase
    end
  end

  // Pads arrive asynchronously
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      padMeta <= '0;
      padSync <= '0;
    end else begin
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : gPinAnalog
      assign analogMask[p] = pinCtl[p].analogEn;
    end
  endgenerate

  // Each input has exactly one select, so two pins never fight over it
  generate
    for (genvar i = 0; i < NIN; i++) begin : gInRoute
      input_route_sel #(
        .NUM_PINS(NUM_PINS)
      ) uSel (
        .clock(clock),
        .rst_b(rst_b),
        .pinLevel(padSync),
        .analogEn(analogMask),
        .sel(inSel[i]),
        .routed(routedIn[i])
      );
    end
  endgenerate

  assign periphIn = pin_select_matrix_pkg::periph_in_type'(routedIn);

  // One select per pin: never two remapped drivers on a pin
  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : gOutDrive
      assign remapOn[p] = codeLive(outSel[p]);
      assign remapData[p] = codeLevel(outSel[p], periphOut);
      output_pin_drive uDrive (
        .clock(clock),
        .rst_b(rst_b),
        .ctl(pinCtl[p]),
        .remapOn(remapOn[p]),
        .remapData(remapData[p]),
        .padOut(padOut[p]),
        .padOeB(padOeB[p])
      );
    end
  endgenerate

endmodule
`default_nettype wire

/* File: test/pin_select_matrix_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_matrix_defines.svh"

module pin_select_matrix_checker #(
  parameter int NUM_PINS = 26
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pads and peripherals
  input wire pin_select_matrix_pkg::pin_ctl_type [NUM_PINS-1:0] pinCtl,
  input wire logic [NUM_PINS-1:0] padOut,
  input wire logic [NUM_PINS-1:0] padOeB,
  input wire pin_select_matrix_pkg::periph_out_type periphOut,
  input wire pin_select_matrix_pkg::periph_in_type periphIn,
  input wire logic routeLocked
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic take, inTake, quiet, wrOsc, outTouched;
  logic [NUM_PINS-1:0] anaV;
  pin_select_matrix_pkg::pin_ctl_type [NUM_PINS-1:0] prevCtl;
  pin_select_matrix_pkg::periph_out_type prevPo;
  assign take = hsel && hready && htrans[1];
  assign inTake = take && hwrite && haddr[11:2] < `IN_ROUTE_REGS;
  // Pin controls and peripheral outputs unchanged, so any buffer change would come from routing
  assign quiet = pinCtl == prevCtl && periphOut == prevPo;
  always_ff @(posedge clock) begin
    prevCtl <= pinCtl;
    prevPo <= periphOut;
    wrOsc <= take && hwrite && haddr[11:2] == `OSC_CTRL_WORD;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      outTouched <= 1'b0;
    end else if (take && hwrite && haddr[11:6] == 6'h01) begin
      outTouched <= 1'b1;
    end
  end
  ok_resp_a: assert property (hresp == `HRESP_OKAY) else $error("bus error response");
  write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  rst_back_a: assert property ($rose(rst_b) |-> periphIn == '0 && padOeB == '1 && !routeLocked)
    else $error("reset state wrong");
  lock_write_a: assert property ($changed(routeLocked) |-> $past(wrOsc) && routeLocked == $past(hwdata[6]))
    else $error("lock moved without its write");
  all_analog_a: assert property (&anaV |=> periphIn == '0) else $error("input seen on analog pin");
  input_no_own_a: assert property (inTake ##2 quiet |=> $stable(padOeB)) else $error("input route moved a buffer");
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    assign anaV[p] = pinCtl[p].analogEn;
    special_wins_a: assert property (pinCtl[p].specialEn |=> !padOeB[p] && padOut[p] == $past(pinCtl[p].specialData))
      else $error("special output lost");
    port_rules_a: assert property (!outTouched && !pinCtl[p].specialEn |=>
      padOeB[p] == $past(pinCtl[p].pinDirectionBit) && padOut[p] == $past(pinCtl[p].portData))
      else $error("null select drove a pin");
  end
  cover property (take && hwrite && routeLocked);
  cover property (&anaV);
  cover property (padOeB != '1);
endmodule

bind pin_select_matrix pin_select_matrix_checker #(.NUM_PINS(NUM_PINS)) i_checker (.clock, .rst_b, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .pinCtl, .padOut, .padOeB, .periphOut, .periphIn,
  .routeLocked);
`default_nettype wire

/* File: test/periph_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none

module periph_pad_model #(
  parameter int NUM_PINS = 26
) (
  // Clock and pacing
  input wire logic clock,
  input wire logic run,
  // Pad wires
  input wire logic [NUM_PINS-1:0] extLevel,
  input wire logic [NUM_PINS-1:0] padOut,
  input wire logic [NUM_PINS-1:0] padOeB,
  output logic [NUM_PINS-1:0] padIn,
  // Peripheral outputs
  output pin_select_matrix_pkg::periph_out_type periphOut
);
  // A released pad shows the board level, a driven one its own data
  assign padIn = (padOeB & extLevel) | (~padOeB & padOut);
  initial periphOut = '0;
  // Held while run is low, so slow and fast peripherals both appear
  always @(posedge clock) begin
    if (run) begin
      periphOut <= {periphOut[17:0], ~(periphOut[18] ^ periphOut[17])};
    end
  end
endmodule
`default_nettype wire

/* File: test/remappable_pin_select_matrix_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_matrix_defines.svh"

module remappable_pin_select_matrix_tb;
  localparam int NP = 26;
  // Live codes, in the order of the output struct from its top bit down
  localparam logic [4:0] LIVE [19] = '{5'h01, 5'h02, 5'h1E, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
    5'h0A, 5'h0B, 5'h0C, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h1D};
  logic clock, rst_b, hsel, hwrite, run, hreadyout, hresp, routeLocked;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [NP-1:0] padIn, padOut, padOeB, extLevel;
  pin_select_matrix_pkg::pin_ctl_type [NP-1:0] pinCtl;
  pin_select_matrix_pkg::periph_out_type periphOut;
  pin_select_matrix_pkg::periph_in_type periphIn;
  logic [5:0] isel [24];
  logic [4:0] osel [NP];
  int n_mismatch, n_compared;

  pin_select_matrix #(.NUM_PINS(NP)) i_dut (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .padIn, .pinCtl, .padOut, .padOeB, .periphOut, .periphIn,
    .routeLocked);
  periph_pad_model #(.NUM_PINS(NP)) i_model (.clock, .run, .extLevel, .padOut, .padOeB, .padIn, .periphOut);

  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    n_compared++;
    if (a !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, a);
    end
  endtask

  // Called just after a rising edge; waits are bounded
  task automatic bus(input logic [9:0] w, input logic wr, input logic [31:0] d, output logic [31:0] r);
    int n;
    hsel <= 1;
    haddr <= {20'h0_0000, w, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    n = 0;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 40);
    r = hrdata;
    if (n >= 40) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic lock_seq(input logic v);
    bus(`OSC_CTRL_WORD, 1, 32'h0000_0046, q);
    bus(`OSC_CTRL_WORD, 1, 32'h0000_0057, q);
    bus(`OSC_CTRL_WORD, 1, {25'h0, v, 6'h00}, q);
    bus(`OSC_CTRL_WORD, 0, 0, q);
  endtask

  function automatic logic exp_in(logic [5:0] s, logic [NP-1:0] lv, pin_select_matrix_pkg::pin_ctl_type [NP-1:0] c);
    exp_in = 1'b0;
    if (s < NP) exp_in = !c[s[4:0]].analogEn && lv[s[4:0]];
  endfunction

  function automatic logic [1:0] exp_pad(logic [4:0] c, logic [18:0] po, pin_select_matrix_pkg::pin_ctl_type t);
    exp_pad = {t.portData, t.pinDirectionBit};
    for (int i = 0; i < 19; i++) if (LIVE[i] == c) exp_pad = {po[18-i], 1'b0};
    if (t.specialEn) exp_pad = {t.specialData, 1'b0};
  endfunction

  initial begin
    rst_b = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    run = 0; extLevel = 0; pinCtl = '0; n_mismatch = 0; n_compared = 0;
    for (int p = 0; p < NP; p++) pinCtl[p].pinDirectionBit = 1;
    void'($urandom(30));
    repeat (2) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    bus(`IN_ROUTE_FIRST, 0, 0, q); chk("input route reset", 32'h0000_3F3F, q);
    bus(`OUT_ROUTE_FIRST, 0, 0, q); chk("output route reset", 0, q);
    bus(`OSC_CTRL_WORD, 0, 0, q); chk("lock reset", 0, q[`LOCK_BIT_POS]);
    $display("test reset ended");
    for (int k = 0; k < 24; k++) isel[k] = 6'($urandom_range(NP + 5, 0));
    isel[1] = isel[0];
    isel[22] = 6'h3F;
    for (int w = 0; w < 12; w++) begin
      bus(10'(`IN_ROUTE_FIRST + w), 1, {18'h0, isel[2*w+1], 2'b00, isel[2*w]}, q);
      bus(10'(`IN_ROUTE_FIRST + w), 0, 0, q);
      // Last word has no upper field, so its upper bits read zero
      if (w == 11) isel[23] = 6'h00;
      chk("input route", {18'h0, isel[2*w+1], 2'b00, isel[2*w]}, q);
    end
    repeat (8) begin
      @(posedge clock);
      extLevel <= NP'($urandom());
      for (int p = 0; p < NP; p++) pinCtl[p].analogEn <= ($urandom_range(3, 0) == 0);
      repeat (5) @(posedge clock);
      for (int k = 0; k < 23; k++) chk("routed input", exp_in(isel[k], extLevel, pinCtl), periphIn[k]);
    end
    // Every pin analog with every pad high: no routed input may see a level
    @(posedge clock);
    extLevel <= '1;
    for (int p = 0; p < NP; p++) pinCtl[p].analogEn <= 1'b1;
    repeat (5) @(posedge clock);
    chk("analog inputs", 0, periphIn);
    $display("test input routing ended");
    for (int p = 0; p < NP; p++) osel[p] = (p < 19) ? LIVE[p] : 5'($urandom());
    osel[19] = 5'h00; osel[20] = 5'h17; osel[21] = 5'h1F; osel[22] = 5'h0D; osel[25] = osel[0];
    for (int w = 0; w < 13; w++) begin
      bus(10'(`OUT_ROUTE_FIRST + w), 1, {19'h0, osel[2*w+1], 3'h0, osel[2*w]}, q);
      bus(10'(`OUT_ROUTE_FIRST + w), 0, 0, q);
      chk("output route", {19'h0, osel[2*w+1], 3'h0, osel[2*w]}, q);
    end
    repeat (8) begin
      @(posedge clock);
      run <= 1;
      for (int p = 0; p < NP; p++) pinCtl[p] <= {1'b0, 4'($urandom())};
      @(posedge clock);
      run <= 0;
      repeat (3) @(posedge clock);
      for (int p = 0; p < NP; p++) chk("pad drive", exp_pad(osel[p], periphOut, pinCtl[p]), {padOut[p], padOeB[p]});
    end
    $display("test output routing ended");
    lock_seq(1); chk("locked", 1, {routeLocked, q[`LOCK_BIT_POS]} == 2'b11);
    bus(`OUT_ROUTE_FIRST, 1, 0, q);
    bus(`IN_ROUTE_FIRST, 1, 0, q);
    bus(`OUT_ROUTE_FIRST, 0, 0, q); chk("locked output route", {19'h0, osel[1], 3'h0, osel[0]}, q);
    bus(`IN_ROUTE_FIRST, 0, 0, q); chk("locked input route", {18'h0, isel[1], 2'b00, isel[0]}, q);
    lock_seq(0); chk("unlocked", 0, routeLocked);
    bus(`OSC_CTRL_WORD, 1, 32'h0000_0057, q);
    bus(`OSC_CTRL_WORD, 1, 32'h0000_0040, q);
    bus(10'h030, 0, 0, q); chk("unmapped word", 0, q);
    chk("keys out of order", 0, routeLocked);
    bus(`OUT_ROUTE_FIRST, 1, 0, q);
    bus(`OUT_ROUTE_FIRST, 0, 0, q); chk("open output route", 0, q);
    $display("test lock ended");
    wrap_up();
  end
endmodule
`default_nettype wire
